// file: hw/lcdcd_pkg.sv
/*
 Constants for the LCD RAM command and data decoder: command codes,
 status layout, RAM geometry, reset values and timing counts.
 Assumes a 20 MHz mclk.
*/
package lcdcd_pkg;
  localparam int CLK_PERIOD_NS = 50;
  // Command execution and initialization times
  localparam int EXEC_TIME_NS = 100;
  localparam int INIT_TIME_NS = 1000;
  localparam int EXEC_CYCLES = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  // RAM geometry
  localparam int NUM_COLUMNS = 166;
  localparam int NUM_PAGES = 9;
  localparam logic [7:0] COL_LAST = 8'hA5;
  localparam logic [3:0] PAGE_INDICATOR = 4'h8;

  // Command codes, upper nibble, upper seven bits or full byte
  localparam logic [3:0] CMD_COL_HIGH = 4'h1;
  localparam logic [3:0] CMD_COL_LOW = 4'h0;
  localparam logic [3:0] CMD_NLINE_SET = 4'h3;
  localparam logic [7:0] CMD_NLINE_RELEASE = 8'h20;
  localparam logic [6:0] CMD_SEG_MAP = 7'h50;
  localparam logic [6:0] CMD_POLARITY = 7'h53;
  localparam logic [6:0] CMD_ALL_ON = 7'h52;
  localparam logic [6:0] CMD_DUTY = 7'h54;
  localparam logic [6:0] CMD_DUTY_PLUS = 7'h55;
  localparam logic [6:0] CMD_DISPLAY = 7'h57;
  localparam logic [7:0] CMD_RMW = 8'hE0;
  localparam logic [7:0] CMD_END = 8'hEE;
  localparam logic [7:0] CMD_RESET = 8'hE2;

  // Status byte bit positions
  localparam int ST_BUSY = 7;
  localparam int ST_MAP = 6;
  localparam int ST_OFF = 5;
  localparam int ST_INIT = 4;

  // Reset values
  localparam logic [7:0] COL_RESET = 8'h00;
  localparam logic [3:0] NLINE_RESET = 4'h0;
endpackage

// file: hw/lcdcd_decoder.sv
/*
 Command and data decoder of a graphic LCD driver with display RAM.
 Assumes the host drives the parallel port pins asynchronously to mclk and
 holds each strobe low for at least three mclk periods; page address comes
 from neighbouring logic on mclk; scan inputs come from the drive timing.
*/
// Behaviour
// - Column address loads from two commands, 0001 high nibble, 0000 low nibble.
// - Column advances after each data write and each parallel data read outside read-modify-write; page never advances.
// - Status read gives busy, mapping, display-off, init; low nibble zero.
// - Busy reads 1 during command execution or init; commands then ignored.
// - Mapping status is 1 for normal order, 0 for reversed order.
// - Display status reads 1 when off, 0 when on.
// - Init status set during init from reset pin or reset command.
// - Data write stores at current page and column, then advances column.
// - Data read returns RAM then advances; host discards one dummy read.
// - No RAM readback over serial interface; writes only.
// - Segment mapping command bit 0 normal, 1 reversed.
// - Polarity bit 0 lights RAM ones, bit 1 lights RAM zeros.
// - All-points-on lights everything, RAM untouched, overrides polarity.
// - All-points-on while display off enters power save.
// - Duty select bit picks duty; independent of output status.
// - Duty plus one adds a line driven from page 8 bit 0.
// - Inversion set stores four-bit code and enables line inversion.
// - Inversion release restores two-frame drive, keeps stored code.
// - Read-modify-write: reads keep column, writes advance, exit restores.
// - End command leaves read-modify-write and restores saved column.
`timescale 1ns/10ps
module lcdcd_decoder
  import lcdcd_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic hardware_init_pin_n,
  input wire logic serial_mode,
  input wire logic command_data_select,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic [3:0] page_address,
  input wire logic [5:0] scan_line,
  input wire logic [7:0] scan_segment,
  output logic segment_lit,
  output logic extra_common_output,
  output logic seg_reverse,
  output logic display_inverse,
  output logic all_points_on,
  output logic display_on,
  output logic power_save,
  output logic duty_select,
  output logic duty_plus_one,
  output logic nline_enable,
  output logic [3:0] nline_code,
  output logic rmw_active,
  output logic [7:0] column_address
);

  // Column counter, RAM depth and busy counter must agree
  if (NUM_COLUMNS != int'(COL_LAST) + 1 || INIT_CYCLES >= (1 << CNT_W)) begin : g_param_check
    $error("geometry or counter width inconsistent");
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Idle levels on reset, so no false strobe edge or init follows it
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic rd_prev;
  logic wr_prev;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pin_meta <= 5'h19;
      pin_sync <= 5'h19;
    end else begin
      pin_meta <= {rd_n, wr_n, command_data_select, serial_mode, hardware_init_pin_n};
      pin_sync <= pin_meta;
    end
  end

  // Data byte is read only after two flip-flops as well
  logic [7:0] data_meta;
  logic [7:0] data_sync;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      data_meta <= 8'h00;
      data_sync <= 8'h00;
    end else begin
      data_meta <= data_in;
      data_sync <= data_meta;
    end
  end

  logic rd_s;
  logic wr_s;
  logic sel_s;
  logic serial_s;
  logic init_pin_s;

  assign rd_s = pin_sync[4];
  assign wr_s = pin_sync[3];
  assign sel_s = pin_sync[2];
  assign serial_s = pin_sync[1];
  assign init_pin_s = pin_sync[0];

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rd_prev <= 1'b1;
      wr_prev <= 1'b1;
    end else begin
      rd_prev <= rd_s;
      wr_prev <= wr_s;
    end
  end

  logic rd_start;
  logic rd_end;
  logic wr_end;

  assign rd_start = rd_prev && !rd_s;
  assign rd_end = !rd_prev && rd_s;
  assign wr_end = !wr_prev && wr_s;

  ////////////////////////////////////////////////////////////////////////
  // Busy and initialization timing

  logic [CNT_W-1:0] busy_count;
  logic init_active;
  logic busy;
  logic cmd_take;
  logic reset_cmd;
  logic data_wr;
  logic data_rd;

  assign busy = (busy_count != '0) || init_active;
  // Commands arriving while busy are dropped
  assign cmd_take = wr_end && !sel_s && !busy;
  assign reset_cmd = cmd_take && (data_sync == CMD_RESET);
  assign data_wr = wr_end && sel_s;
  // Serial interface has no readback path
  assign data_rd = rd_end && sel_s && !serial_s;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      busy_count <= CNT_W'(INIT_CYCLES);
      init_active <= 1'b1;
    end else if (!init_pin_s || reset_cmd) begin
      busy_count <= CNT_W'(INIT_CYCLES);
      init_active <= 1'b1;
    end else if (cmd_take) begin
      busy_count <= CNT_W'(EXEC_CYCLES);
    end else if (busy_count != '0) begin
      busy_count <= busy_count - CNT_W'(1);
    end else begin
      init_active <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Column address and read-modify-write

  logic [7:0] next_column;
  logic [7:0] column_saved;
  logic [7:0] col_inc;
  logic init_any;

  assign init_any = !init_pin_s || reset_cmd;
  // Saturate at the last column instead of wrapping
  assign col_inc = (column_address == COL_LAST) ? COL_LAST : column_address + 8'h01;

  always_comb begin
    next_column = column_address;
    if (cmd_take && data_sync[7:4] == CMD_COL_HIGH && !rmw_active) begin
      next_column = {data_sync[3:0], column_address[3:0]};
    end else if (cmd_take && data_sync[7:4] == CMD_COL_LOW && !rmw_active) begin
      next_column = {column_address[7:4], data_sync[3:0]};
    end else if (cmd_take && data_sync == CMD_END && rmw_active) begin
      next_column = column_saved;
    end else if (data_wr) begin
      next_column = col_inc;
    end else if (data_rd && !rmw_active) begin
      next_column = col_inc;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      column_address <= COL_RESET;
    end else if (init_any) begin
      column_address <= COL_RESET;
    end else begin
      column_address <= next_column;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rmw_active <= 1'b0;
      column_saved <= COL_RESET;
    end else if (init_any) begin
      rmw_active <= 1'b0;
    end else if (cmd_take && data_sync == CMD_RMW) begin
      rmw_active <= 1'b1;
      column_saved <= column_address;
    end else if (cmd_take && data_sync == CMD_END) begin
      rmw_active <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Display RAM

  logic [7:0] ram [NUM_PAGES][NUM_COLUMNS];
  logic [7:0] read_buf;
  logic addr_ok;

  assign addr_ok = (page_address < 4'(NUM_PAGES)) && (column_address <= COL_LAST);

  always_ff @(posedge mclk) begin
    if (data_wr && addr_ok) begin
      ram[page_address][column_address] <= data_sync;
    end
  end

  // Read buffer is refilled after each parallel data read; first read returns stale data
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      read_buf <= 8'h00;
    end else if (data_rd) begin
      read_buf <= addr_ok ? ram[page_address][column_address] : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Host read port

  logic [7:0] status_byte;

  always_comb begin
    status_byte = 8'h00;
    status_byte[ST_BUSY] = busy;
    status_byte[ST_MAP] = !seg_reverse;
    status_byte[ST_OFF] = !display_on;
    status_byte[ST_INIT] = init_active;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      data_out <= 8'h00;
    end else if (rd_start) begin
      data_out <= sel_s ? (serial_s ? 8'h00 : read_buf) : status_byte;
    end
  end

  assign data_oe = !rd_s;

  ////////////////////////////////////////////////////////////////////////
  // Mode commands

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      seg_reverse <= 1'b0;
      display_inverse <= 1'b0;
      all_points_on <= 1'b0;
      display_on <= 1'b0;
      duty_select <= 1'b0;
      duty_plus_one <= 1'b0;
    end else if (cmd_take) begin
      case (data_sync[7:1])
        CMD_SEG_MAP: seg_reverse <= data_sync[0];
        CMD_POLARITY: display_inverse <= data_sync[0];
        CMD_ALL_ON: all_points_on <= data_sync[0];
        CMD_DISPLAY: display_on <= data_sync[0];
        CMD_DUTY: duty_select <= data_sync[0];
        CMD_DUTY_PLUS: duty_plus_one <= data_sync[0];
        default: begin
        end
      endcase
    end
  end

  // Power save is entered by all-on while off and left by either undoing
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      power_save <= 1'b0;
    end else if (!init_pin_s) begin
      power_save <= 1'b0;
    end else if (cmd_take && data_sync[7:1] == CMD_ALL_ON) begin
      power_save <= data_sync[0] && !display_on;
    end else if (cmd_take && data_sync[7:1] == CMD_DISPLAY && data_sync[0]) begin
      power_save <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      nline_enable <= 1'b0;
      nline_code <= NLINE_RESET;
    end else if (init_any) begin
      nline_enable <= 1'b0;
      nline_code <= NLINE_RESET;
    end else if (cmd_take && data_sync[7:4] == CMD_NLINE_SET) begin
      nline_enable <= 1'b1;
      nline_code <= data_sync[3:0];
    end else if (cmd_take && data_sync == CMD_NLINE_RELEASE) begin
      nline_enable <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Scan path to segment and common drivers

  logic [7:0] scan_column;
  logic scan_ok;
  logic ram_bit;
  logic ind_bit;

  assign scan_column = seg_reverse ? COL_LAST - scan_segment : scan_segment;
  assign scan_ok = scan_segment <= COL_LAST;
  assign ram_bit = scan_ok ? ram[scan_line[5:3]][scan_column][scan_line[2:0]] : 1'b0;
  assign ind_bit = scan_ok ? ram[PAGE_INDICATOR][scan_column][0] : 1'b0;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      segment_lit <= 1'b0;
      extra_common_output <= 1'b0;
    end else begin
      // All-on wins over polarity
      segment_lit <= all_points_on || (ram_bit ^ display_inverse);
      extra_common_output <= duty_plus_one && ind_bit;
    end
  end

endmodule

// file: test/lcdcd_sva.sv
/*
 Checker on the decoder's ports: status byte, column counting, modes.
 Assumes it is bound onto every lcdcd_decoder instance.
*/
`timescale 1ns/10ps
module lcdcd_sva
  import lcdcd_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic serial_mode,
  input wire logic command_data_select,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic segment_lit,
  input wire logic seg_reverse,
  input wire logic all_points_on,
  input wire logic display_on,
  input wire logic power_save,
  input wire logic nline_enable,
  input wire logic [3:0] nline_code,
  input wire logic [7:0] column_address
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////
  // Checked at the end of a read, once the answer byte has stood
  AST_ST_LOW: assert property ($fell(data_oe) && !command_data_select |-> data_out[3:0] == 4'h0)
    else $error("status low bits not zero");
  AST_ST_MAP: assert property ($fell(data_oe) && !command_data_select |-> data_out[ST_MAP] == !seg_reverse)
    else $error("status mapping bit wrong");
  AST_ST_OFF: assert property ($fell(data_oe) && !command_data_select |-> data_out[ST_OFF] == !display_on)
    else $error("status display bit wrong");
  AST_ST_BUSY: assert property ($fell(data_oe) && !command_data_select && data_out[ST_INIT] |-> data_out[ST_BUSY])
    else $error("init without busy");
  AST_SERIAL: assert property ($fell(data_oe) && command_data_select && serial_mode |-> data_out == 8'h00)
    else $error("serial readback not blocked");
  AST_COL_MAX: assert property (column_address <= COL_LAST)
    else $error("column past last");
  // Data accesses only ever step the column by one
  AST_COL_STEP: assert property ($changed(column_address) && command_data_select |-> column_address == $past(column_address) + 8'h01)
    else $error("column step wrong");
  AST_PSAVE: assert property ($rose(power_save) |-> all_points_on && !display_on)
    else $error("power save without cause");
  AST_NLINE: assert property ($fell(nline_enable) && nline_code != NLINE_RESET |-> $stable(nline_code))
    else $error("release changed line code");
  AST_LIT: assert property (all_points_on && display_on && $past(all_points_on && display_on) |-> segment_lit)
    else $error("all points not lit");
  cover property ($rose(power_save));
  cover property ($fell(nline_enable));
  cover property ($rose(all_points_on) && display_on);
endmodule
bind lcdcd_decoder lcdcd_sva u_sva (
  .mclk(mclk),
  .resetn(resetn),
  .serial_mode(serial_mode),
  .command_data_select(command_data_select),
  .data_out(data_out),
  .data_oe(data_oe),
  .segment_lit(segment_lit),
  .seg_reverse(seg_reverse),
  .all_points_on(all_points_on),
  .display_on(display_on),
  .power_save(power_save),
  .nline_enable(nline_enable),
  .nline_code(nline_code),
  .column_address(column_address)
);

// file: test/lcdcd_host.sv
/*
 Host processor model on the parallel command/data port.
 Assumes the bench calls xfer for one transfer at a time.
*/
`timescale 1ns/10ps
module lcdcd_host (
  input wire logic mclk,
  input wire logic [7:0] data_out,
  output logic command_data_select,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] data_in
);
  initial begin
    command_data_select = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    data_in = 8'hA5;
  end
  ////////////////////////////////////////////////////////////////////////
  // Select leads the strobe; low 4 and high 6 also cover command busy time
  task automatic xfer(input logic sel, input logic rd, input logic [7:0] wd, output logic [7:0] q);
    @(posedge mclk);
    command_data_select <= sel;
    if (!rd) begin
      data_in <= wd;
    end
    @(posedge mclk);
    rd_n <= !rd;
    wr_n <= rd;
    repeat (4) @(posedge mclk);
    q = data_out;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    repeat (6) @(posedge mclk);
    data_in <= ~data_in; // Released bus must not keep the old byte
  endtask
endmodule

// file: test/testbench.sv
/*
 Self-checking bench for the command and data decoder.
 Assumes the package, host model and checker are compiled before it.
*/
`timescale 1ns/10ps
module testbench;
  import lcdcd_pkg::*;
  logic mclk;
  logic resetn = 1'b0;
  logic hardware_init_pin_n = 1'b1;
  logic serial_mode = 1'b0;
  logic [3:0] page_address = 4'h2;
  logic [5:0] scan_line = 6'h00;
  logic [7:0] scan_segment = 8'h00;
  logic command_data_select, rd_n, wr_n, data_oe, segment_lit, extra_common_output;
  logic seg_reverse, display_inverse, all_points_on, display_on, power_save;
  logic duty_select, duty_plus_one, nline_enable, rmw_active;
  logic [7:0] data_in, data_out, column_address, q;
  logic [3:0] nline_code;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  // Command byte and the mode vector expected after it
  logic [7:0] rc [18] = '{8'hAF, 8'hA1, 8'hA7, 8'hA5, 8'hA4, 8'hA9, 8'hAB, 8'h3F, 8'h20,
    8'h31, 8'hA0, 8'hA6, 8'hA8, 8'hAA, 8'hAE, 8'hA5, 8'hA4, 8'h20};
  logic [11:0] rv [18] = '{12'h080, 12'h480, 12'h680, 12'h780, 12'h680, 12'h6C0, 12'h6E0,
    12'h6FF, 12'h6EF, 12'h6F1, 12'h2F1, 12'h0F1, 12'h0B1, 12'h091, 12'h011, 12'h911,
    12'h011, 12'h001};
  lcdcd_decoder u_dut (
    .mclk(mclk),
    .resetn(resetn),
    .hardware_init_pin_n(hardware_init_pin_n),
    .serial_mode(serial_mode),
    .command_data_select(command_data_select),
    .rd_n(rd_n),
    .wr_n(wr_n),
    .data_in(data_in),
    .data_out(data_out),
    .data_oe(data_oe),
    .page_address(page_address),
    .scan_line(scan_line),
    .scan_segment(scan_segment),
    .segment_lit(segment_lit),
    .extra_common_output(extra_common_output),
    .seg_reverse(seg_reverse),
    .display_inverse(display_inverse),
    .all_points_on(all_points_on),
    .display_on(display_on),
    .power_save(power_save),
    .duty_select(duty_select),
    .duty_plus_one(duty_plus_one),
    .nline_enable(nline_enable),
    .nline_code(nline_code),
    .rmw_active(rmw_active),
    .column_address(column_address)
  );
  lcdcd_host u_host (
    .mclk(mclk),
    .data_out(data_out),
    .command_data_select(command_data_select),
    .rd_n(rd_n),
    .wr_n(wr_n),
    .data_in(data_in)
  );
  ////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    scan_segment <= scan_segment + 8'h01;
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] b);
    u_host.xfer(1'b0, 1'b0, b, q);
  endtask
  task automatic dwr(input logic [7:0] b);
    u_host.xfer(1'b1, 1'b0, b, q);
  endtask
  task automatic drd(input logic sel);
    u_host.xfer(sel, 1'b1, 8'h00, q);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    // Command during init is dropped, init shows busy
    cmd(8'hA1);
    drd(1'b0);
    chk(q, 8'hF0);
    chk(seg_reverse, 1'b0);
    repeat (30) @(posedge mclk);
    drd(1'b0);
    chk(q, 8'h60);
    // Every mode command, with status after each; no follower in this setup
    for (int i = 0; i < 18; i++) begin
      cmd(rc[i]);
      chk({power_save, seg_reverse, display_inverse, all_points_on, display_on, duty_select,
        duty_plus_one, nline_enable, nline_code}, rv[i]);
      drd(1'b0);
      chk(q, {1'b0, ~rv[i][10], ~rv[i][7], 5'h00});
    end
    // Column load, writes to the last column, then readback
    cmd(8'h1A);
    cmd(8'h04);
    chk(column_address, 8'hA4);
    dwr(8'h5A);
    dwr(8'hC3);
    chk(column_address, COL_LAST);
    cmd(8'h04);
    cmd(8'h1A);
    drd(1'b1);
    drd(1'b1);
    chk(q, 8'h5A);
    drd(1'b1);
    chk(q, 8'hC3);
    // Read-modify-write, with a refused column load inside
    cmd(8'h11);
    cmd(8'h00);
    dwr(8'hAA);
    cmd(8'h00);
    cmd(8'hE0);
    drd(1'b1);
    chk(column_address, 8'h10);
    dwr(8'h55);
    cmd(8'h12);
    chk(column_address, 8'h11);
    cmd(8'hEE);
    chk({rmw_active, column_address}, 12'h010);
    drd(1'b1);
    drd(1'b1);
    chk(q, 8'h55);
    // Serial mode read gives nothing and keeps the column
    serial_mode <= 1'b1;
    drd(1'b1);
    chk(q, 8'h00);
    chk(column_address, 8'h12);
    serial_mode <= 1'b0;
    // Reset command, then the init pin
    cmd(8'hE2);
    drd(1'b0);
    chk(q, 8'hF0);
    chk({nline_code, column_address}, 12'h000);
    repeat (30) @(posedge mclk);
    cmd(8'h15);
    chk(column_address, 8'h50);
    hardware_init_pin_n <= 1'b0;
    repeat (4) @(posedge mclk);
    hardware_init_pin_n <= 1'b1;
    drd(1'b0);
    chk(q, 8'hF0);
    chk(column_address, 8'h00);
    // Indicator bit reaches the extra common line only with duty plus one
    repeat (30) @(posedge mclk);
    page_address <= PAGE_INDICATOR;
    cmd(8'h10);
    cmd(8'h03);
    dwr(8'h01);
    for (int k = 0; k < 2; k++) begin
      while (scan_segment != 8'h03) @(posedge mclk);
      @(negedge mclk);
      chk(extra_common_output, k[0]);
      cmd(8'hAB);
    end
    tally_and_finish();
  end
endmodule
